// ===== inc/epcs_defs.svh
// offsets, field positions, reset values and timing of the counter snapshot bank
`ifndef EPCS_DEFS_SVH
`define EPCS_DEFS_SVH

// ======================================================
// register indices, byte address is four times the index
`define EPCS_IDX_CRC_LO    6'h00
`define EPCS_IDX_CRC_HI    6'h01
`define EPCS_IDX_FRM_LO    6'h02
`define EPCS_IDX_FRM_HI    6'h03
`define EPCS_IDX_ALIGN     6'h04
`define EPCS_IDX_SYNC      6'h05
`define EPCS_IDX_PAT_LO    6'h06
`define EPCS_IDX_PAT_HI    6'h07
`define EPCS_IDX_LINE_LO   6'h08
`define EPCS_IDX_LINE_HI   6'h09
`define EPCS_IDX_CTRL      6'h10

// ======================================================
// monitor control fields and crc4 high field position
`define EPCS_CTRL_AUTO_BIT   0
`define EPCS_CTRL_MANUAL_BIT 1
`define EPCS_CTRL_HDB3_BIT   2
`define EPCS_CTRL_RESET      3'h0
`define EPCS_CRC_HI_POS      4

// ======================================================
// counter widths
`define EPCS_CRC_W   10
`define EPCS_FRM_W   12
`define EPCS_ALIGN_W 3
`define EPCS_SYNC_W  5
`define EPCS_PAT_W   16
`define EPCS_LINE_W  16

// ======================================================
// timing
`define EPCS_CLK_PERIOD_NS    50
`define EPCS_UPDATE_PERIOD_NS 1000000000
`define EPCS_UPDATE_CYCLES    (`EPCS_UPDATE_PERIOD_NS / `EPCS_CLK_PERIOD_NS)

`endif

// ===== inc/epcs_pkg.sv
// types of the counter snapshot bank
`default_nettype none
package epcs_pkg;
    typedef struct packed {
        logic crc4_err;
        logic frame_pattern_err;
        logic align_shift;
        logic sync_loss;
        logic pattern_detector_err;
        logic bipolar_viol;
        logic code_viol;
    } epcs_events_t;

    typedef struct packed {
        logic hdb3_sel;
        logic manual_latch_bit;
        logic auto_latch_bit;
    } epcs_ctrl_t;
endpackage
`default_nettype wire

// ===== logic/epcs_top.sv
// counter snapshot bank with avalon-mm slave
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "epcs_defs.svh"

// ======================================================
// one event counter with its snapshot
module epcs_counter #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         evt_i,
    input  wire logic         latch_i,
    output logic [W-1:0]      count_o,
    output logic [W-1:0]      snap_o
);
    // saturates rather than wrapping
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_o <= '0;
        end else if (latch_i) begin
            count_o <= {{(W-1){1'b0}}, evt_i};
        end else if (evt_i && !(&count_o)) begin
            count_o <= count_o + 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            snap_o <= '0;
        end else if (latch_i) begin
            snap_o <= count_o;
        end
    end

    property p_snap_takes_count;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        latch_i |=> snap_o == $past(count_o);
    endproperty
    a_snap_takes_count: assert property (p_snap_takes_count)
        else $error("snapshot missed the counter value");

    property p_restart_keeps_event;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        latch_i |=> count_o == {{(W-1){1'b0}}, $past(evt_i)};
    endproperty
    a_restart_keeps_event: assert property (p_restart_keeps_event)
        else $error("counter restart lost or doubled an event");

    property p_snap_holds;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !latch_i |=> $stable(snap_o);
    endproperty
    a_snap_holds: assert property (p_snap_holds)
        else $error("snapshot changed without a group update");
endmodule

// ======================================================
// top: control, update timing, register read path
module epcs_top
    import epcs_pkg::*;
#(
    parameter int UPDATE_CYCLES = `EPCS_UPDATE_CYCLES
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [7:0]   avs_address_i,
    input  wire logic         avs_read_i,
    input  wire logic         avs_write_i,
    input  wire logic [31:0]  avs_writedata_i,
    input  wire logic [3:0]   avs_byteenable_i,
    output logic [31:0]       avs_readdata_o,
    output logic              avs_waitrequest_o,
    input  wire epcs_events_t events_i
);
    localparam int SW = $clog2(UPDATE_CYCLES + 1);

    epcs_ctrl_t                 ctrl;
    logic                       manual_q;
    logic                       manual_rise;
    logic [SW-1:0]              sec_cnt;
    logic                       sec_tick;
    logic                       latch;
    logic                       line_evt;
    logic                       rd_ack;
    logic [7:0]                 next_rd_byte;
    logic [5:0]                 idx;
    logic [`EPCS_CRC_W-1:0]     crc_cnt;
    logic [`EPCS_CRC_W-1:0]     crc_snap;
    logic [`EPCS_FRM_W-1:0]     frm_cnt;
    logic [`EPCS_FRM_W-1:0]     frm_snap;
    logic [`EPCS_ALIGN_W-1:0]   align_cnt;
    logic [`EPCS_ALIGN_W-1:0]   align_snap;
    logic [`EPCS_SYNC_W-1:0]    sync_cnt;
    logic [`EPCS_SYNC_W-1:0]    sync_snap;
    logic [`EPCS_PAT_W-1:0]     pat_cnt;
    logic [`EPCS_PAT_W-1:0]     pat_snap;
    logic [`EPCS_LINE_W-1:0]    line_cnt;
    logic [`EPCS_LINE_W-1:0]    line_snap;

    assign idx = avs_address_i[7:2];

    // ======================================================
    // monitor control register
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl <= `EPCS_CTRL_RESET;
        end else if (avs_write_i && avs_byteenable_i[0] && idx == `EPCS_IDX_CTRL) begin
            ctrl.auto_latch_bit   <= avs_writedata_i[`EPCS_CTRL_AUTO_BIT];
            ctrl.manual_latch_bit <= avs_writedata_i[`EPCS_CTRL_MANUAL_BIT];
            ctrl.hdb3_sel         <= avs_writedata_i[`EPCS_CTRL_HDB3_BIT];
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            manual_q <= 1'b0;
        end else begin
            manual_q <= ctrl.manual_latch_bit;
        end
    end

    assign manual_rise = ctrl.manual_latch_bit && !manual_q;

    // ======================================================
    // one second timer, runs only while auto update is on
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sec_cnt <= '0;
        end else if (!ctrl.auto_latch_bit || sec_tick) begin
            sec_cnt <= '0;
        end else begin
            sec_cnt <= sec_cnt + 1'b1;
        end
    end

    assign sec_tick = ctrl.auto_latch_bit && sec_cnt == SW'(UPDATE_CYCLES - 1);
    assign latch    = manual_rise || sec_tick;

    // ======================================================
    // event counters and snapshots
    assign line_evt = ctrl.hdb3_sel ? events_i.code_viol : events_i.bipolar_viol;

    epcs_counter #(.W(`EPCS_CRC_W)) u_crc (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (events_i.crc4_err),
        .latch_i   (latch),
        .count_o   (crc_cnt),
        .snap_o    (crc_snap)
    );

    epcs_counter #(.W(`EPCS_FRM_W)) u_frm (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (events_i.frame_pattern_err),
        .latch_i   (latch),
        .count_o   (frm_cnt),
        .snap_o    (frm_snap)
    );

    epcs_counter #(.W(`EPCS_ALIGN_W)) u_align (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (events_i.align_shift),
        .latch_i   (latch),
        .count_o   (align_cnt),
        .snap_o    (align_snap)
    );

    epcs_counter #(.W(`EPCS_SYNC_W)) u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (events_i.sync_loss),
        .latch_i   (latch),
        .count_o   (sync_cnt),
        .snap_o    (sync_snap)
    );

    epcs_counter #(.W(`EPCS_PAT_W)) u_pat (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (events_i.pattern_detector_err),
        .latch_i   (latch),
        .count_o   (pat_cnt),
        .snap_o    (pat_snap)
    );

    epcs_counter #(.W(`EPCS_LINE_W)) u_line (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .evt_i     (line_evt),
        .latch_i   (latch),
        .count_o   (line_cnt),
        .snap_o    (line_snap)
    );

    // ======================================================
    // read path: one wait cycle, data from flip-flops
    always_comb begin
        next_rd_byte = 8'h00;
        case (idx)
            `EPCS_IDX_CRC_LO:  next_rd_byte = crc_snap[7:0];
            `EPCS_IDX_CRC_HI:  next_rd_byte = {2'h0, crc_snap[9:8], 4'h0};
            `EPCS_IDX_FRM_LO:  next_rd_byte = frm_snap[7:0];
            `EPCS_IDX_FRM_HI:  next_rd_byte = {4'h0, frm_snap[11:8]};
            `EPCS_IDX_ALIGN:   next_rd_byte = {5'h00, align_snap};
            `EPCS_IDX_SYNC:    next_rd_byte = {3'h0, sync_snap};
            `EPCS_IDX_PAT_LO:  next_rd_byte = pat_snap[7:0];
            `EPCS_IDX_PAT_HI:  next_rd_byte = pat_snap[15:8];
            `EPCS_IDX_LINE_LO: next_rd_byte = line_snap[7:0];
            `EPCS_IDX_LINE_HI: next_rd_byte = line_snap[15:8];
            `EPCS_IDX_CTRL:    next_rd_byte = {5'h00, ctrl};
            default:           next_rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_ack <= 1'b0;
        end else begin
            rd_ack <= avs_read_i && !rd_ack;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (avs_read_i && !rd_ack) begin
            avs_readdata_o <= {24'h00_0000, next_rd_byte};
        end
    end

    assign avs_waitrequest_o = avs_read_i && !rd_ack;

    // ======================================================
    // checks
    property p_manual_edge_loads;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(ctrl.manual_latch_bit) |=> crc_snap == $past(crc_cnt) && line_snap == $past(line_cnt);
    endproperty
    a_manual_edge_loads: assert property (p_manual_edge_loads)
        else $error("manual update did not load the group");

    property p_manual_level_no_reload;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ctrl.manual_latch_bit && manual_q && !sec_tick |-> !latch;
    endproperty
    a_manual_level_no_reload: assert property (p_manual_level_no_reload)
        else $error("update fired on a held manual bit");

    property p_auto_period;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        $rose(ctrl.auto_latch_bit) && !manual_rise |-> !latch [*2];
    endproperty
    a_auto_period: assert property (p_auto_period)
        else $error("auto update fired before a full second");

    property p_auto_tick;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ctrl.auto_latch_bit && sec_cnt == SW'(UPDATE_CYCLES - 1) |=> sec_cnt == '0 && pat_snap == $past(pat_cnt);
    endproperty
    a_auto_tick: assert property (p_auto_tick)
        else $error("one second update missed");

    property p_crc_low_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_CRC_LO && !latch |=> avs_readdata_o == {24'h00_0000, crc_snap[7:0]};
    endproperty
    a_crc_low_read: assert property (p_crc_low_read)
        else $error("crc4 low byte read wrong");

    property p_crc_high_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_CRC_HI |=>
            avs_readdata_o[`EPCS_CRC_HI_POS+1:`EPCS_CRC_HI_POS] == $past(crc_snap[9:8])
            && avs_readdata_o[3:0] == 4'h0 && avs_readdata_o[31:6] == 26'h0;
    endproperty
    a_crc_high_read: assert property (p_crc_high_read)
        else $error("crc4 high bits misplaced");

    property p_frame_high_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_FRM_HI |=> avs_readdata_o == {28'h0, $past(frm_snap[11:8])};
    endproperty
    a_frame_high_read: assert property (p_frame_high_read)
        else $error("frame error high nibble read wrong");

    property p_align_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_ALIGN |=> avs_readdata_o == {29'h0, $past(align_snap)};
    endproperty
    a_align_read: assert property (p_align_read)
        else $error("alignment shift field read wrong");

    property p_sync_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_SYNC |=> avs_readdata_o == {27'h0, $past(sync_snap)};
    endproperty
    a_sync_read: assert property (p_sync_read)
        else $error("sync loss field read wrong");

    property p_pattern_high_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack && idx == `EPCS_IDX_PAT_HI |=> avs_readdata_o == {24'h0, $past(pat_snap[15:8])};
    endproperty
    a_pattern_high_read: assert property (p_pattern_high_read)
        else $error("pattern detector high byte read wrong");

    property p_line_select;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        !latch && !(&line_cnt) && (ctrl.hdb3_sel ? events_i.code_viol : events_i.bipolar_viol)
            |=> line_cnt == $past(line_cnt) + 16'h0001;
    endproperty
    a_line_select: assert property (p_line_select)
        else $error("line violation from the wrong decoder");

    property p_read_one_wait;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        avs_read_i && !rd_ack |-> avs_waitrequest_o ##1 !avs_waitrequest_o;
    endproperty
    a_read_one_wait: assert property (p_read_one_wait)
        else $error("read not answered after one wait cycle");
endmodule
`default_nettype wire

// ===== testbench/epcs_top_tb_top.sv
// self-checking testbench of the counter snapshot bank
`timescale 1ns/1ps
`default_nettype none
`include "epcs_defs.svh"

module epcs_top_tb_top
    import epcs_pkg::*;
;
    localparam int UPD = 20;

    logic         sys_clk_i        = 1'b0;
    logic         rst_n_i          = 1'b0;
    logic [7:0]   avs_address_i    = 8'h00;
    logic         avs_read_i       = 1'b0;
    logic         avs_write_i      = 1'b0;
    logic [31:0]  avs_writedata_i  = 32'h0;
    logic [3:0]   avs_byteenable_i = 4'h0;
    logic [31:0]  avs_readdata_o;
    logic         avs_waitrequest_o;
    epcs_events_t events_i         = '0;

    int           cnt[6]           = '{0, 0, 0, 0, 0, 0};
    int           snap[6]          = '{0, 0, 0, 0, 0, 0};
    int           maxv[6]          = '{1023, 4095, 7, 31, 65535, 65535};
    logic [31:0]  seed             = 32'hd3a8;
    logic         hdb3             = 1'b0;
    int           bad_count        = 0;
    int           num_checks       = 0;

    epcs_top #(.UPDATE_CYCLES(UPD)) uut (
        .sys_clk_i         (sys_clk_i),
        .rst_n_i           (rst_n_i),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (avs_byteenable_i),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o),
        .events_i          (events_i)
    );

    always #25 sys_clk_i = ~sys_clk_i;

    // ======================================================
    // reference model
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        x = x ^ (x << 5);
        return x;
    endfunction

    function automatic logic [31:0] exp_reg(input int idx);
        logic [31:0] v;
        v = 32'h0;
        case (idx)
            0: v[7:0] = snap[0][7:0];
            1: v[5:4] = snap[0][9:8];
            2: v[7:0] = snap[1][7:0];
            3: v[3:0] = snap[1][11:8];
            4: v[2:0] = snap[2][2:0];
            5: v[4:0] = snap[3][4:0];
            6: v[7:0] = snap[4][7:0];
            7: v[7:0] = snap[4][15:8];
            8: v[7:0] = snap[5][7:0];
            9: v[7:0] = snap[5][15:8];
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    task automatic bump(input int i);
        if (cnt[i] < maxv[i]) begin
            cnt[i]++;
        end
    endtask

    task automatic count_events(input epcs_events_t e);
        if (e.crc4_err) bump(0);
        if (e.frame_pattern_err) bump(1);
        if (e.align_shift) bump(2);
        if (e.sync_loss) bump(3);
        if (e.pattern_detector_err) bump(4);
        if (hdb3 ? e.code_viol : e.bipolar_viol) bump(5);
    endtask

    task automatic snap_update();
        for (int i = 0; i < 6; i++) begin
            snap[i] = cnt[i];
            cnt[i] = 0;
        end
    endtask

    // ======================================================
    // checks and closing report
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    // ======================================================
    // avalon-mm master
    task automatic bus_xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                            input logic [3:0] be, output logic [31:0] rd);
        logic done;
        done = 1'b0;
        rd = 32'h0;
        @(posedge sys_clk_i);
        avs_read_i <= ~wr;
        avs_write_i <= wr;
        avs_address_i <= {idx, 2'b00};
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        // sample at the rising edge itself, before the design's flops update
        for (int n = 0; n < 20 && !done; n++) begin
            @(posedge sys_clk_i);
            if (avs_waitrequest_o === 1'b0) begin
                rd = avs_readdata_o;
                done = 1'b1;
            end
        end
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        if (!done) begin
            $display("unexpected waitrequest expected 0 seen 1");
            bad_count++;
            summarize();
        end
    endtask

    task automatic wr_reg(input logic [5:0] idx, input logic [31:0] wd, input logic [3:0] be);
        logic [31:0] d;
        bus_xfer(1'b1, idx, wd, be, d);
    endtask

    task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus_xfer(1'b0, idx, 32'h0, 4'hf, d);
        check_word($sformatf("readdata idx %0h", idx), exp, d);
    endtask

    // ======================================================
    // stimulus
    task automatic drive_events(input int n, input bit hold);
        logic [6:0] ev;
        repeat (n) begin
            @(posedge sys_clk_i);
            seed = xorshift(seed);
            ev = hold ? 7'h7f : seed[6:0];
            events_i <= ev;
            count_events(ev);
        end
        @(posedge sys_clk_i);
        events_i <= '0;
    endtask

    task automatic manual_update();
        wr_reg(`EPCS_IDX_CTRL, {29'h0, hdb3, 2'b00}, 4'hf);
        wr_reg(`EPCS_IDX_CTRL, {29'h0, hdb3, 2'b10}, 4'hf);
        // pulse on the update edge starts the fresh count
        events_i <= 7'h40;
        @(posedge sys_clk_i);
        events_i <= '0;
        snap_update();
        cnt[0] = 1;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 10; i++) rd_chk(i[5:0], 32'h0);
        rd_chk(`EPCS_IDX_CTRL, 32'h0);
        rd_chk(6'h3f, 32'h0);
        wr_reg(6'h00, 32'hff, 4'hf);
        wr_reg(6'h3f, 32'hff, 4'hf);
        rd_chk(6'h00, 32'h0);
        rd_chk(6'h3f, 32'h0);
        for (int r = 0; r < 3; r++) begin
            hdb3 = r[0];
            wr_reg(`EPCS_IDX_CTRL, {29'h0, hdb3, 2'b00}, 4'hf);
            seed = xorshift(seed);
            drive_events((r == 2) ? 1030 : 40 + int'(seed[3:0]), r == 2);
            manual_update();
            for (int i = 0; i < 10; i++) rd_chk(i[5:0], exp_reg(i));
            wr_reg(`EPCS_IDX_CTRL, 32'h0, 4'h0);
            rd_chk(`EPCS_IDX_CTRL, {29'h0, hdb3, 2'b10});
        end
        // auto refresh with a short period
        hdb3 = 1'b0;
        wr_reg(`EPCS_IDX_CTRL, 32'h1, 4'hf);
        drive_events(8, 1'b0);
        rd_chk(6'h00, exp_reg(0));
        repeat (12) @(posedge sys_clk_i);
        snap_update();
        rd_chk(6'h00, exp_reg(0));
        rd_chk(6'h05, exp_reg(5));
        repeat (14) @(posedge sys_clk_i);
        snap_update();
        rd_chk(6'h00, exp_reg(0));
        wr_reg(`EPCS_IDX_CTRL, 32'h0, 4'hf);
        summarize();
    end
endmodule
`default_nettype wire
